// ==== logic/bri_pkg.sv ====
package bri_pkg;
	// Fragment size selection codes
	typedef enum logic [1:0] {
		BRI_SIZE_256,
		BRI_SIZE_384,
		BRI_SIZE_512
	} bri_size_t;
	// Index widths and fragment lengths
	localparam int BRI_IDX_W = 9;
	localparam logic [8:0] BRI_LEN_256 = 9'h100;
	localparam logic [8:0] BRI_LEN_512_LAST = 9'h1FF;
	localparam logic [8:0] BRI_PRUNE_LIMIT = 9'h180;
	localparam logic [8:0] BRI_ZERO = 9'h000;
	localparam logic [8:0] BRI_ONE = 9'h001;
	localparam logic [1:0] BRI_SIZE_BITS_8 = 2'h0;
endpackage

// ==== logic/bri_reverse.sv ====
module bri_reverse
	import bri_pkg::*;
#(
	parameter int W = 9
) (
	input wire logic [W-1:0] cnt,
	input wire logic short_mode,
	output logic [W-1:0] idx
);
	// Reversal needs at least two bits
	if (W < 2) begin : g_bad_w
		$error("bri_reverse: width too small");
	end
	logic [W-1:0] rev9;
	logic [W-2:0] rev8;
	// Mirror the counter bits: top bit of the counter lands in the index LSB
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_rev9
			assign rev9[i] = cnt[W-1-i];
		end
		for (i = 0; i < W - 1; i++) begin : g_rev8
			assign rev8[i] = cnt[W-2-i];
		end
	endgenerate
	// Short mode reverses only the low eight counter bits
	assign idx = short_mode ? {1'b0, rev8} : rev9;
endmodule

// ==== logic/bri_interleaver.sv ====
module bri_interleaver
	import bri_pkg::*;
#(
	parameter int SYM_W = 1
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [1:0] frag_size,
	input wire logic in_valid,
	input wire logic [SYM_W-1:0] in_sym,
	output logic in_ready,
	output logic out_valid,
	output logic [SYM_W-1:0] out_sym,
	output logic out_last,
	input wire logic out_ready
);
	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// A zero-width symbol leaves nothing to store or emit
	if (SYM_W < 1) begin : g_bad_sym_w
		$error("bri_interleaver: SYM_W must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////
	// Types and storage

	// Two phases: collect a whole fragment, then play it out permuted
	typedef enum logic [1:0] {BRI_FILL, BRI_DRAIN} bri_state_t;

	// Phase, and the size held for the whole fragment
	bri_state_t state_q, state_d;
	bri_size_t size_q;
	// Write position, read sweep counter and output position
	logic [BRI_IDX_W-1:0] wr_cnt_q;
	logic [BRI_IDX_W-1:0] rd_cnt_q;
	logic [BRI_IDX_W-1:0] out_pos_q;
	// One fragment of symbols, deep enough for the largest size
	logic [SYM_W-1:0] mem_q [0:(1<<BRI_IDX_W)-1];
	// Registered handshake and output slot
	logic in_ready_q;
	logic out_valid_q;
	logic out_last_q;
	logic [SYM_W-1:0] out_sym_q;

	////////////////////////////////////////////////////////////////////////
	// Size decode

	// Current fragment size, one flag each for the 256 and 384 sweeps
	wire logic is_256 = (size_q == BRI_SIZE_256);
	wire logic is_384 = (size_q == BRI_SIZE_384);
	// Only the three defined codes may replace the held size
	wire logic sel_ok = (frag_size == BRI_SIZE_256) || (frag_size == BRI_SIZE_384) || (frag_size == BRI_SIZE_512);

	// Last symbol index of a fragment, also its last output position
	logic [BRI_IDX_W-1:0] wr_last;
	// Last sweep value: 8-bit sweep for 256, full 9-bit sweep otherwise
	logic [BRI_IDX_W-1:0] rd_last;
	assign wr_last = is_256 ? (BRI_LEN_256 - BRI_ONE) : is_384 ? (BRI_PRUNE_LIMIT - BRI_ONE) : BRI_LEN_512_LAST;
	assign rd_last = is_256 ? (BRI_LEN_256 - BRI_ONE) : BRI_LEN_512_LAST;

	////////////////////////////////////////////////////////////////////////
	// Write side

	// A symbol is taken on each edge where both sides agree
	wire logic wr_fire = in_ready_q && in_valid;

	// The write into the final slot closes the fill phase
	wire logic wr_done = wr_fire && (wr_cnt_q == wr_last);

	// The size may change only while idle, before a fragment's first symbol,
	// so a late change cannot split one fragment across two shapes
	wire logic size_load = (state_q == BRI_FILL) && (wr_cnt_q == BRI_ZERO) && !wr_fire && sel_ok;

	////////////////////////////////////////////////////////////////////////
	// Read side

	// Read index: the sweep counter mirrored bit for bit
	logic [BRI_IDX_W-1:0] rd_idx;

	bri_reverse #(.W(BRI_IDX_W)) u_rev (
		.cnt(rd_cnt_q),
		.short_mode(is_256),
		.idx(rd_idx)
	);

	// Indices at or above the fragment length are skipped in 384 mode;
	// each skipped index costs one cycle that loads no symbol into the slot
	wire logic pruned = is_384 && (rd_idx >= BRI_PRUNE_LIMIT);

	// The output slot can take a new symbol when empty or being emptied
	wire logic slot_free = !out_valid_q || out_ready;

	// A kept index fills the slot; a pruned one fills nothing
	wire logic rd_take = (state_q == BRI_DRAIN) && slot_free && !pruned;

	// Pruned steps never wait for the slot, so a stall cannot hold them up
	wire logic rd_step = (state_q == BRI_DRAIN) && (slot_free || pruned);

	// The final counter value ends the sweep, kept or pruned
	wire logic rd_end = rd_step && (rd_cnt_q == rd_last);

	// The output position moves only on kept indices and marks the last one
	wire logic out_end = rd_take && (out_pos_q == wr_last);

	// Slot occupancy after this edge
	wire logic out_valid_d = slot_free ? rd_take : out_valid_q;

	// Room for the next fragment only once the slot no longer holds this one,
	// so nothing new is accepted before every output has gone
	wire logic in_ready_d = (state_d == BRI_FILL) && !wr_done && !out_valid_d;

	////////////////////////////////////////////////////////////////////////
	// Phase control

	// Fill until the whole fragment is held, then drain
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			BRI_FILL: if (wr_done) state_d = BRI_DRAIN;
			BRI_DRAIN: if (rd_end) state_d = BRI_FILL;
			default: state_d = BRI_FILL;
		endcase
	end

	// Phase register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= BRI_FILL;
		end else begin
			state_q <= state_d;
		end
	end

	// Size held for the whole fragment; an undefined code keeps the last one
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			size_q <= BRI_SIZE_256;
		end else if (size_load) begin
			size_q <= bri_size_t'(frag_size);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counters

	// Write position wraps to zero once the fragment is complete
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_cnt_q <= BRI_ZERO;
		end else if (wr_fire) begin
			wr_cnt_q <= wr_done ? BRI_ZERO : wr_cnt_q + BRI_ONE;
		end
	end

	// Sweep counter starts at zero, so the first read is symbol zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_cnt_q <= BRI_ZERO;
		end else if (rd_step) begin
			rd_cnt_q <= rd_end ? BRI_ZERO : rd_cnt_q + BRI_ONE;
		end
	end

	// Output position counts kept symbols only
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_pos_q <= BRI_ZERO;
		end else if (rd_take) begin
			out_pos_q <= out_end ? BRI_ZERO : out_pos_q + BRI_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Handshake and storage

	// Input handshake, registered so the port comes from a flip-flop
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			in_ready_q <= 1'b0;
		end else begin
			in_ready_q <= in_ready_d;
		end
	end

	// Input symbols stored at their arrival index
	always_ff @(posedge clk_sys) begin
		if (wr_fire) begin
			mem_q[wr_cnt_q] <= in_sym;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output slot

	// Slot flags load on a free slot and hold while downstream stalls
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_valid_q <= 1'b0;
			out_last_q <= 1'b0;
		end else if (slot_free) begin
			out_valid_q <= rd_take;
			out_last_q <= out_end;
		end
	end

	// Slot data is the stored symbol at the reversed index
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_sym_q <= '0;
		end else if (rd_take) begin
			out_sym_q <= mem_q[rd_idx];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Every port is a register output
	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_sym = out_sym_q;
	assign out_last = out_last_q;
endmodule

// ==== bench/bri_monitor.sv ====
module bri_monitor import bri_pkg::*; #(parameter int SYM_W = 1) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_last,
	input wire logic out_ready,
	input wire logic [1:0] frag_size,
	input wire logic [SYM_W-1:0] in_sym,
	input wire logic [SYM_W-1:0] out_sym);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Fill and drain handover
	chk_rst_exit: assert property ($past(srst) |-> !out_valid && !in_ready ##1 in_ready) else $error("rst");
	chk_one_side: assert property (in_ready |-> !out_valid) else $error("side");
	chk_fill_end: assert property ($fell(in_ready) |-> $past(in_valid)) else $error("fill");
	chk_drain_go: assert property ($fell(in_ready) |-> ##[1:2] out_valid) else $error("go");
	chk_refill: assert property (out_valid && out_ready && out_last |=> in_ready) else $error("refill");
	// Output stream holds while stalled
	chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sym)) else $error("hold");
	chk_out_drop: assert property ($fell(out_valid) |-> $past(out_ready)) else $error("drop");
	chk_last_valid: assert property (out_last |-> out_valid) else $error("last");
	cover property (out_last && out_ready);
	cover property (out_valid && !out_ready);
	cover property ($fell(in_ready));
endmodule
bind bri_interleaver bri_monitor #(.SYM_W(SYM_W)) i_mon (
	.clk_sys(clk_sys),
	.srst(srst),
	.in_valid(in_valid),
	.in_ready(in_ready),
	.out_valid(out_valid),
	.out_last(out_last),
	.out_ready(out_ready),
	.frag_size(frag_size),
	.in_sym(in_sym),
	.out_sym(out_sym));

// ==== bench/bri_sink.sv ====
module bri_sink (
	input wire logic clk_sys,
	input wire logic slow,
	output logic out_ready = 1'b0);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] n_q = 2'h0;
	// Downstream takes every cycle, or one in four when slow
	always @(posedge clk_sys) begin
		n_q <= n_q + 2'h1;
		out_ready <= #1 !slow || n_q == 2'h0;
	end
endmodule

// ==== bench/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bri_pkg::*;
	logic clk_sys = 0, srst = 1, in_valid = 0, slow = 0, in_ready, out_valid, out_last, out_ready;
	logic [1:0] frag_size = BRI_SIZE_BITS_8;
	logic [8:0] in_sym = BRI_ZERO, out_sym;
	int err_count = 0, cmp_count = 0;
	bri_interleaver #(.SYM_W(9)) i_dut (.clk_sys, .srst, .frag_size, .in_valid, .in_sym, .in_ready,
		.out_valid, .out_sym, .out_last, .out_ready);
	bri_sink i_sink (.clk_sys, .slow, .out_ready);
	initial forever #5 clk_sys = ~clk_sys;
	task stop_test;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [8:0] s, e, input string nm);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s exp %h got %h", nm, e, s);
		end
	endtask
	// Feed symbols 0..len-1, then check the permuted stream
	task frag(input logic [1:0] sz, input int len);
		logic [8:0] m, r;
		int k;
		frag_size = sz;
		in_sym = BRI_ZERO;
		@(posedge clk_sys);
		#1 in_valid = 1;
		for (int i = 0; i < len;) begin
			@(posedge clk_sys);
			if (in_ready) i++;
			#1 in_sym = i[8:0];
			in_valid = i < len;
		end
		k = 0;
		for (int j = 0; j < (len == 256 ? 256 : 512); j++) begin
			m = j[8:0];
			r = {<<{m}};
			r = r >> (len == 256);
			if (r < len) begin
				do @(posedge clk_sys); while (!(out_valid && out_ready));
				chk(out_sym, r, "sym");
				k++;
				chk(out_last, k == len, "last");
			end
		end
		@(posedge clk_sys);
		#1 chk({in_ready, out_valid}, 9'h002, "ready");
		$display("fragment %0d done", len);
	endtask
	task t256;
		frag(BRI_SIZE_256, 256);
	endtask
	task t384;
		frag(BRI_SIZE_384, 384);
	endtask
	task t512;
		slow = 1;
		frag(BRI_SIZE_512, 512);
		slow = 0;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		#1 srst = 0;
		t256;
		t384;
		t512;
		stop_test;
	end
	initial begin
		#300000;
		err_count++;
		stop_test;
	end
endmodule
